// [design/casmp_port.sv]
// Memory-side port logic for an 8-bit strobe-timed DRAM bus with center-aligned read strobe
`timescale 1ns/1ps
module casmp_port import casmp_pkg::*; #(
	parameter int ADDR_W = 8,
	parameter logic [7:0] LATENCY = CASMP_LATENCY_DEF
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic bus_clock,
	input wire logic phase_shifted_clock,
	input wire logic chip_select_n,
	input wire logic reset_n,
	input wire logic [7:0] dq_i,
	output logic [7:0] dq_o,
	output logic dq_oe_n,
	input wire logic read_write_strobe_mask_i,
	output logic read_write_strobe_mask_o,
	output logic read_write_strobe_mask_oe_n,
	input wire logic extra_latency,
	output logic frame_active,
	output logic [15:0] frame_count
);
	////////////////////////////////////////////////////////////////////////////
	// Link domain resets
	logic link_rst;
	logic sync_rst;
	assign sync_rst = rst | ~reset_n;
	// Frame state is cleared by chip select itself, since the bus clock stops after a frame
	assign link_rst = sync_rst | chip_select_n;

	////////////////////////////////////////////////////////////////////////////
	// Extra latency level into the bus clock domain
	logic xl_s1_q, xl_s2_q;
	always_ff @(posedge bus_clock or posedge sync_rst) begin
		if (sync_rst) begin
			xl_s1_q <= 1'b0;
			xl_s2_q <= 1'b0;
		end else begin
			xl_s1_q <= extra_latency;
			xl_s2_q <= xl_s1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Transaction engine on the bus clock
	logic [7:0] mem [0:(1<<ADDR_W)-1];
	casmp_state_t state_q, state_d;
	logic [2:0] ca_cnt_q, ca_cnt_d;
	logic [7:0] lat_q, lat_d;
	logic rd_q, rd_d;
	logic [ADDR_W-1:0] addr_q, addr_d;
	logic [7:0] dq_q, dq_d;
	logic dq_oe_n_q, dq_oe_n_d;
	logic read_write_strobe_mask_oe_n_q, read_write_strobe_mask_oe_n_d;
	logic xl_frame_q, xl_frame_d;
	logic mem_we;

	always_comb begin
		state_d = state_q;
		ca_cnt_d = ca_cnt_q;
		lat_d = lat_q;
		rd_d = rd_q;
		addr_d = addr_q;
		dq_d = dq_q;
		dq_oe_n_d = 1'b1;
		read_write_strobe_mask_oe_n_d = 1'b1;
		xl_frame_d = xl_frame_q;
		mem_we = 1'b0;
		case (state_q)
			CASMP_CMD: begin
				// Strobe is an output through the command phase to flag latency
				read_write_strobe_mask_oe_n_d = 1'b0;
				if (ca_cnt_q == 3'h0) begin
					rd_d = dq_i[CASMP_RD_BIT];
					xl_frame_d = xl_s2_q;
				end
				if (ca_cnt_q == CASMP_CA_LAST) begin
					addr_d = dq_i[ADDR_W-1:0];
					lat_d = xl_frame_q ? 8'(LATENCY << 1) : LATENCY;
					state_d = CASMP_LAT;
				end else begin
					ca_cnt_d = 3'(ca_cnt_q + 3'h1);
				end
			end
			CASMP_LAT: begin
				read_write_strobe_mask_oe_n_d = ~rd_q;
				if (lat_q <= 8'h01) begin
					if (rd_q) begin
						state_d = CASMP_RD;
						dq_d = mem[addr_q];
						dq_oe_n_d = 1'b0;
						addr_d = ADDR_W'(addr_q + 1'b1);
					end else begin
						state_d = CASMP_WR;
					end
				end else begin
					lat_d = 8'(lat_q - 8'h01);
				end
			end
			CASMP_RD: begin
				read_write_strobe_mask_oe_n_d = 1'b0;
				dq_oe_n_d = 1'b0;
				dq_d = mem[addr_q];
				addr_d = ADDR_W'(addr_q + 1'b1);
			end
			CASMP_WR: begin
				// Strobe stays an input here: a high level masks the byte
				mem_we = ~read_write_strobe_mask_i;
				addr_d = ADDR_W'(addr_q + 1'b1);
			end
			default: begin
				state_d = CASMP_CMD;
			end
		endcase
	end

	always_ff @(posedge bus_clock or posedge link_rst) begin
		if (link_rst) begin
			state_q <= CASMP_CMD;
			ca_cnt_q <= 3'h0;
			lat_q <= 8'h00;
			rd_q <= 1'b0;
			addr_q <= '0;
			dq_q <= CASMP_DQ_RST;
			dq_oe_n_q <= 1'b1;
			read_write_strobe_mask_oe_n_q <= 1'b1;
			xl_frame_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ca_cnt_q <= ca_cnt_d;
			lat_q <= lat_d;
			rd_q <= rd_d;
			addr_q <= addr_d;
			dq_q <= dq_d;
			dq_oe_n_q <= dq_oe_n_d;
			read_write_strobe_mask_oe_n_q <= read_write_strobe_mask_oe_n_d;
			xl_frame_q <= xl_frame_d;
		end
	end

	// Storage keeps its contents across resets, like the array behind the pins
	always_ff @(posedge bus_clock) begin
		if (mem_we) begin
			mem[addr_q] <= dq_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Strobe level, timed by the phase-shifted clock
	logic read_write_strobe_mask_q, read_write_strobe_mask_d;
	always_comb begin
		read_write_strobe_mask_d = read_write_strobe_mask_q;
		if (state_q == CASMP_RD) begin
			read_write_strobe_mask_d = ~read_write_strobe_mask_q;
		end else begin
			read_write_strobe_mask_d = 1'b0;
		end
	end

	always_ff @(posedge phase_shifted_clock or posedge link_rst) begin
		if (link_rst) begin
			read_write_strobe_mask_q <= 1'b0;
		end else begin
			read_write_strobe_mask_q <= read_write_strobe_mask_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Latency flag on the bus clock, since writes may hold the phase-shifted clock still
	logic flag_q, flag_d;
	always_comb begin
		flag_d = 1'b0;
		if (state_q == CASMP_CMD) begin
			flag_d = xl_s2_q;
		end
	end

	always_ff @(posedge bus_clock or posedge link_rst) begin
		if (link_rst) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Frame status on the system clock
	logic cs_s1_q, cs_s2_q, cs_s3_q;
	logic act_q, act_d;
	logic [15:0] cnt_q, cnt_d;
	always_comb begin
		act_d = ~cs_s2_q;
		cnt_d = cnt_q;
		// Rising chip select closes a frame
		if (cs_s2_q && !cs_s3_q) begin
			cnt_d = 16'(cnt_q + 16'h0001);
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cs_s1_q <= 1'b1;
			cs_s2_q <= 1'b1;
			cs_s3_q <= 1'b1;
			act_q <= 1'b0;
			cnt_q <= CASMP_CNT_RST;
		end else begin
			cs_s1_q <= chip_select_n;
			cs_s2_q <= cs_s1_q;
			cs_s3_q <= cs_s2_q;
			act_q <= act_d;
			cnt_q <= cnt_d;
		end
	end

	assign dq_o = dq_q;
	assign dq_oe_n = dq_oe_n_q;
	// Flag and toggle flops are never high together, so the merge cannot glitch
	assign read_write_strobe_mask_o = read_write_strobe_mask_q | flag_q;
	assign read_write_strobe_mask_oe_n = read_write_strobe_mask_oe_n_q;
	assign frame_active = act_q;
	assign frame_count = cnt_q;
endmodule

// [inc/casmp_pkg.sv]
// Constants and types shared by the center-aligned strobe memory port
package casmp_pkg;
	localparam int CASMP_CA_BYTES = 6;
	localparam logic [2:0] CASMP_CA_LAST = 3'h5;
	localparam int CASMP_RD_BIT = 7;
	localparam logic [7:0] CASMP_LATENCY_DEF = 8'h04;
	localparam logic [7:0] CASMP_DQ_RST = 8'h00;
	localparam logic [15:0] CASMP_CNT_RST = 16'h0000;
	typedef enum logic [3:0] {
		CASMP_CMD = 4'b0001,
		CASMP_LAT = 4'b0010,
		CASMP_RD = 4'b0100,
		CASMP_WR = 4'b1000
	} casmp_state_t;
endpackage

// [verification/casmp_host_model.sv]
// Host side model: link clocks, select and host data
`timescale 1ns/1ps
module casmp_host_model (
	output logic bus_clock,
	output logic phase_shifted_clock,
	output logic chip_select_n,
	output logic [7:0] host_dq,
	output logic host_mask,
	input wire logic [7:0] dq
);
	initial begin
		bus_clock = 0;
		phase_shifted_clock = 0;
		chip_select_n = 1;
		host_dq = 0;
		host_mask = 0;
	end
	task automatic frame(input logic rd, input logic [7:0] a, input int l,
		input logic [31:0] wd, input logic [3:0] m, output logic [31:0] rv);
		// Idle pulses let the latency flag settle
		repeat (3) begin
			#24 bus_clock = 1;
			#24 bus_clock = 0;
		end
		chip_select_n = 0;
		for (int e = 0; e < 10 + l; e++) begin
			host_dq = e == 0 ? {rd, 7'h00} : e == 5 ? a : e > 5 + l ? wd[8*(e-6-l)+:8] : ~host_dq;
			host_mask = !rd && e > 5 + l && m[e-6-l];
			#12 bus_clock = 1;
			#12 phase_shifted_clock = rd;
			if (rd && e >= 5 + l && e < 9 + l)
				rv[8*(e-5-l)+:8] = dq;
			#12 bus_clock = 0;
			#12 phase_shifted_clock = 0;
		end
		chip_select_n = 1;
		host_dq = ~host_dq;
	endtask
endmodule

// [verification/casmp_port_checker.sv]
// Pin-level checks of the strobe memory port
`timescale 1ns/1ps
module casmp_port_checker import casmp_pkg::*; (
	input wire logic clock,
	input wire logic rst,
	input wire logic bus_clock,
	input wire logic phase_shifted_clock,
	input wire logic chip_select_n,
	input wire logic reset_n,
	input wire logic extra_latency,
	input wire logic [7:0] dq_i,
	input wire logic dq_oe_n,
	input wire logic read_write_strobe_mask_o,
	input wire logic read_write_strobe_mask_oe_n,
	input wire logic frame_active
);
	sequence start_s;
		$fell(chip_select_n);
	endsequence
	sequence wr_s;
		start_s ##0 !dq_i[CASMP_RD_BIT];
	endsequence
	hiz_reset_a: assert property (@(posedge clock) disable iff (rst)
		!reset_n |-> dq_oe_n && read_write_strobe_mask_oe_n) else $error("bus driven in reset");
	idle_free_a: assert property (@(posedge clock) disable iff (rst)
		chip_select_n |-> dq_oe_n && read_write_strobe_mask_oe_n) else $error("bus driven idle");
	lat_flag_a: assert property (@(posedge bus_clock) disable iff (rst || !reset_n)
		start_s ##2 !chip_select_n |-> !read_write_strobe_mask_oe_n
		&& read_write_strobe_mask_o == extra_latency) else $error("latency flag wrong");
	wr_quiet_a: assert property (@(posedge bus_clock) disable iff (rst || !reset_n)
		wr_s |-> dq_oe_n [*8]) else $error("data driven in write");
	rd_toggle_a: assert property (@(posedge phase_shifted_clock) disable iff (rst || !reset_n)
		!dq_oe_n [*3] |-> read_write_strobe_mask_o != $past(read_write_strobe_mask_o))
		else $error("strobe stuck in read");
	frame_open_a: assert property (@(posedge clock) disable iff (rst)
		$fell(chip_select_n) |-> ##[2:4] frame_active) else $error("frame start missed");
	frame_close_a: assert property (@(posedge clock) disable iff (rst)
		$rose(chip_select_n) |-> ##[2:4] !frame_active) else $error("frame end missed");
endmodule
bind casmp_port casmp_port_checker i_casmp_port_checker (
	.clock(clock),
	.rst(rst),
	.bus_clock(bus_clock),
	.phase_shifted_clock(phase_shifted_clock),
	.chip_select_n(chip_select_n),
	.reset_n(reset_n),
	.extra_latency(extra_latency),
	.dq_i(dq_i),
	.dq_oe_n(dq_oe_n),
	.read_write_strobe_mask_o(read_write_strobe_mask_o),
	.read_write_strobe_mask_oe_n(read_write_strobe_mask_oe_n),
	.frame_active(frame_active)
);

// [verification/tb_top.sv]
// Self-checking bench for the strobe memory port
`timescale 1ns/1ps
module tb_top import casmp_pkg::*;;
	logic clock = 0, rst = 1, reset_n = 0, extra_latency = 0;
	wire logic bus_clock, phase_shifted_clock, chip_select_n, host_mask, read_write_strobe_mask_i;
	wire logic [7:0] host_dq, dq_i;
	logic [7:0] dq_o;
	logic dq_oe_n, read_write_strobe_mask_o, read_write_strobe_mask_oe_n, frame_active;
	logic [15:0] frame_count;
	logic [31:0] rv, wd, nd;
	logic [3:0] m;
	int error_cnt = 0, num_checks = 0;
	always #12.5 clock = ~clock;
	assign dq_i = dq_oe_n ? host_dq : dq_o;
	assign read_write_strobe_mask_i = read_write_strobe_mask_oe_n ? host_mask : read_write_strobe_mask_o;
	casmp_port i_casmp_port (
		.clock(clock),
		.rst(rst),
		.bus_clock(bus_clock),
		.phase_shifted_clock(phase_shifted_clock),
		.chip_select_n(chip_select_n),
		.reset_n(reset_n),
		.dq_i(dq_i),
		.dq_o(dq_o),
		.dq_oe_n(dq_oe_n),
		.read_write_strobe_mask_i(read_write_strobe_mask_i),
		.read_write_strobe_mask_o(read_write_strobe_mask_o),
		.read_write_strobe_mask_oe_n(read_write_strobe_mask_oe_n),
		.extra_latency(extra_latency),
		.frame_active(frame_active),
		.frame_count(frame_count)
	);
	casmp_host_model i_casmp_host_model (
		.bus_clock(bus_clock),
		.phase_shifted_clock(phase_shifted_clock),
		.chip_select_n(chip_select_n),
		.host_dq(host_dq),
		.host_mask(host_mask),
		.dq(dq_i)
	);
	function automatic int lat(input logic el);
		return el ? 2 * int'(CASMP_LATENCY_DEF) : int'(CASMP_LATENCY_DEF);
	endfunction
	function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] k);
		for (int j = 0; j < 4; j++)
			if (k[j])
				n[8*j+:8] = o[8*j+:8];
		return n;
	endfunction
	task automatic chk(input string s, input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %s exp %h got %h", s, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr_rd(input logic [7:0] ad);
		@(posedge clock) #1 extra_latency = 1'($urandom);
		wd = $urandom;
		nd = $urandom;
		m = 4'($urandom);
		i_casmp_host_model.frame(0, ad, lat(extra_latency), wd, 4'h0, rv);
		i_casmp_host_model.frame(0, ad, lat(extra_latency), nd, m, rv);
		i_casmp_host_model.frame(1, ad, lat(extra_latency), $urandom, 4'h0, rv);
		chk("rdata", rv, merge(wd, nd, m));
	endtask
	initial begin
		void'($urandom(90));
		repeat (12) @(posedge clock);
		#1 rst = 0;
		reset_n = 1;
		// First address wraps past the top of the array
		for (int k = 0; k < 8; k++) begin
			wr_rd(k == 0 ? 8'hFE : 8'($urandom));
			repeat (5) @(posedge clock);
			chk("frames", frame_count, 3 * k + 3);
			chk("idle", frame_active, 0);
		end
		fork
			i_casmp_host_model.frame(1, 8'h10, lat(extra_latency), 0, 4'h0, rv);
			begin
				repeat (28) @(posedge clock);
				#1 reset_n = 0;
				@(posedge clock) #1 chk("hiz", {dq_oe_n, read_write_strobe_mask_oe_n}, 2'b11);
				chk("active", frame_active, 1);
				reset_n = 1;
			end
		join
		wr_rd(8'h20);
		end_sim();
	end
endmodule
